// ### rtl/sensor_external_io_control.v
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_io_map.vh"

module sensor_external_io_control #(
    // counts above 4096 cycles are parameters so simulation can shorten them
    parameter [31:0] BANK_DELAY_CYC = `MS_CYCLES(`BANK_DELAY_MS),
    parameter [31:0] BANK_MAX_CYC = `MS_CYCLES(`BANK_MAX_MS),
    parameter [31:0] ZERO_MIN_CYC = `MS_CYCLES(`ZERO_MIN_MS),
    parameter [31:0] ZERO_MAX_CYC = `MS_CYCLES(`ZERO_MAX_MS),
    parameter [31:0] ZERO_CANCEL_CYC = `MS_CYCLES(`ZERO_CANCEL_MS)
) (
    input wire sys_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // external input wires, asynchronous
    input wire input_wire_zero,
    input wire input_wire_one,
    input wire input_wire_two,
    input wire input_wire_three,
    // measurement core, same clock
    input wire meas_active,
    input wire meas_valid,
    input wire [2:0] meas_judge,
    input wire [15:0] meas_linear,
    input wire bank_done,
    input wire batch_stream_command,
    // outputs toward the pins and the core
    output reg [2:0] judge_out,
    output reg [15:0] linear_out,
    output reg trigger_pulse,
    output reg reset_active,
    output reg laser_disable_input,
    output reg zero_reset_apply,
    output reg zero_reset_cancel,
    output reg zero_active,
    output reg [1:0] bank_sel,
    output reg bank_change_start,
    output reg busy,
    output reg batch_stream_accept,
    output reg batch_stream_reject,
    // effective cycle, same units as the base cycle
    output reg [16:0] eff_cycle
);

    // software registers
    reg [31:0] ctrl_r; // behaviour and mode settings
    reg [3:0] polarity_r; // 1: wire active when on
    reg [15:0] base_cycle_r; // normal measurement cycle
    reg ack_r; // bus answer phase

    // decoded control fields
    // plain slices, so a write acts on the next edge
    wire hold_mode = ctrl_r[`CTRL_HOLD_BIT];
    wire volt_out = ctrl_r[`CTRL_VOLT_BIT];
    wire [2:0] clamp_sel = ctrl_r[`CTRL_CLAMP_LO+2:`CTRL_CLAMP_LO];
    wire bank_assign = ctrl_r[`CTRL_BANK_BIT];
    wire digital_on = ctrl_r[`CTRL_DIGITAL_BIT];
    wire [1:0] meas_mode = ctrl_r[`CTRL_MODE_LO+1:`CTRL_MODE_LO];
    wire hold_type = ctrl_r[`CTRL_HOLDTYPE_BIT];

    // bus handshake: every access waits exactly one cycle
    // the fixed wait lets the read mux settle into a register
    // before the master takes the data
    wire bus_req = avs_read | avs_write; // either direction asks
    // a write lands only in the answer cycle
    wire wr_take = avs_write & ack_r;
    // combinational, seen by the master in the request cycle
    assign avs_waitrequest = bus_req & ~ack_r;

    // answer phase toggles so back to back requests each wait once
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            // request cycle raises it, answer cycle drops it
            ack_r <= bus_req & ~ack_r;
        end
    end

    // register writes land at the edge where waitrequest is low
    reg [31:0] ctrl_nxt;
    always @* begin
        ctrl_nxt = ctrl_r;
        if (wr_take && avs_address == `ADDR_CTRL) begin
            // whole word taken, unused bits cleared below
            ctrl_nxt = avs_writedata;
            // upper bits are unused and read zero
            ctrl_nxt[31:11] = 21'h000000;
            // spare bit between clamp and mode fields
            ctrl_nxt[7] = 1'b0;
        end
        // high-speed mode forces the digital setting off
        // checked on the next value, so write and clear share one edge
        if (ctrl_nxt[`CTRL_MODE_LO+1:`CTRL_MODE_LO] == `MODE_HIGH) begin
            ctrl_nxt[`CTRL_DIGITAL_BIT] = 1'b0;
        end
    end

    // configuration registers
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RESET;
            polarity_r <= `POLARITY_RESET;
            base_cycle_r <= `BASE_CYCLE_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            // only the low four bits hold polarity
            if (wr_take && avs_address == `ADDR_POLARITY) begin
                polarity_r <= avs_writedata[3:0];
            end
            // base cycle is 16 bits, upper half ignored
            if (wr_take && avs_address == `ADDR_BASE_CYCLE) begin
                base_cycle_r <= avs_writedata[15:0];
            end
        end
    end

    // read mux, captured in the wait cycle so data stands with the answer
    reg [31:0] rd_mux;
    always @* begin
        // status bits 3:2 are spare and read zero
        case (avs_address)
            `ADDR_CTRL: rd_mux = ctrl_r;
            `ADDR_POLARITY: rd_mux = {28'h0000000, polarity_r};
            `ADDR_BASE_CYCLE: rd_mux = {16'h0000, base_cycle_r};
            `ADDR_STATUS: rd_mux = {24'h000000, busy, zero_active,
                                    laser_disable_input, reset_active,
                                    2'h0, bank_sel};
            `ADDR_EFF_CYCLE: rd_mux = {15'h0000, eff_cycle};
            default: rd_mux = 32'h00000000; // unmapped reads zero
        endcase
    end

    // read data register
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            // wait cycle only, so data stands through the answer
            avs_readdata <= rd_mux;
        end
    end

    // two-stage synchroniser on the four pins
    // polarity is applied after the second stage, never before
    reg [3:0] pin_meta_r; // first stage, read only by second
    reg [3:0] pin_sync_r; // second stage
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            // low pins with reset polarity leave no wire asserted
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= {input_wire_three, input_wire_two,
                           input_wire_one, input_wire_zero};
            pin_sync_r <= pin_meta_r;
        end
    end

    // polarity: asserted when the level matches the wire's active level
    wire [3:0] asserted = ~(pin_sync_r ^ polarity_r);
    reg [3:0] asserted_d_r; // previous asserted levels for edges

    // reset low matches the idle asserted level, so no false edge
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            asserted_d_r <= 4'h0;
        end else begin
            asserted_d_r <= asserted;
        end
    end

    // wire functions; trigger and reset exist only in standard assignment
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            trigger_pulse <= 1'b0;
            reset_active <= 1'b0;
            laser_disable_input <= 1'b0;
        end else begin
            // trigger fires once on the asserted edge
            trigger_pulse <= ~bank_assign & asserted[0] & ~asserted_d_r[0];
            // reset is a level, held while the wire is asserted
            reset_active <= ~bank_assign & asserted[1];
            // laser off works in both assignments
            laser_disable_input <= asserted[2];
        end
    end

    // zero reset pulse width measurement on wire three
    reg [31:0] zero_cnt_r; // cycles the wire has been asserted
    reg cancel_done_r; // cancel already issued for this press
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            zero_cnt_r <= 32'h00000000;
            cancel_done_r <= 1'b0;
            zero_reset_apply <= 1'b0;
            zero_reset_cancel <= 1'b0;
            zero_active <= 1'b0;
        end else begin
            // both answers are one-cycle pulses
            zero_reset_apply <= 1'b0;
            zero_reset_cancel <= 1'b0;
            if (asserted[3]) begin
                // saturate so a stuck wire never wraps into a valid width
                if (zero_cnt_r != 32'hffffffff) begin
                    zero_cnt_r <= zero_cnt_r + 32'h00000001;
                end
                // cancel as soon as the long hold is reached
                if (zero_cnt_r + 32'h00000001 == ZERO_CANCEL_CYC && !cancel_done_r) begin
                    cancel_done_r <= 1'b1;
                    zero_reset_cancel <= 1'b1;
                    zero_active <= 1'b0;
                end
            end else begin
                // release: a pulse inside the window applies the zero reset
                if (asserted_d_r[3] && zero_cnt_r >= ZERO_MIN_CYC
                        && zero_cnt_r <= ZERO_MAX_CYC) begin
                    zero_reset_apply <= 1'b1;
                    zero_active <= 1'b1;
                end
                // the next press counts from zero
                zero_cnt_r <= 32'h00000000;
                cancel_done_r <= 1'b0;
            end
        end
    end

    // bank select: A is the high bit, B the low bit
    wire [1:0] bank_raw = {asserted[0], asserted[1]};
    reg [1:0] bank_seen_r; // last sampled select state
    reg [31:0] bank_dly_r; // cycles since the select state changed
    reg bank_pend_r; // a change waits for its delay
    reg [31:0] busy_cnt_r; // cycles spent in the current change

    // debounce the select, start the change after the delay
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            bank_seen_r <= 2'h0;
            bank_dly_r <= 32'h00000000;
            bank_pend_r <= 1'b0;
            bank_sel <= 2'h0;
            bank_change_start <= 1'b0;
        end else begin
            bank_change_start <= 1'b0;
            // compared with its last sample on every edge
            bank_seen_r <= bank_raw;
            // standard assignment: nothing pends, nothing starts
            if (!bank_assign) begin
                bank_pend_r <= 1'b0;
                bank_dly_r <= 32'h00000000;
            end else if (bank_raw != bank_seen_r) begin
                // any new change restarts the wait
                bank_pend_r <= (bank_raw != bank_sel);
                bank_dly_r <= 32'h00000000;
            end else if (bank_pend_r) begin
                // select has stood unchanged for the whole delay
                if (bank_dly_r + 32'h00000001 >= BANK_DELAY_CYC) begin
                    bank_pend_r <= 1'b0;
                    bank_sel <= bank_raw;
                    bank_change_start <= 1'b1;
                end else begin
                    bank_dly_r <= bank_dly_r + 32'h00000001;
                end
            end
        end
    end

    // busy from the start until the core finishes or time runs out
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            busy_cnt_r <= 32'h00000000;
        end else if (bank_change_start) begin
            // a new start restarts the timeout
            busy <= 1'b1;
            busy_cnt_r <= 32'h00000000;
        end else if (busy) begin
            // a core that never answers cannot hold busy past the limit
            if (bank_done || busy_cnt_r + 32'h00000001 >= BANK_MAX_CYC) begin
                busy <= 1'b0;
            end
            // runs one cycle past the fall, harmless
            busy_cnt_r <= busy_cnt_r + 32'h00000001;
        end
    end

    // batch stream command gate
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            batch_stream_accept <= 1'b0;
            batch_stream_reject <= 1'b0;
        end else begin
            // one answer per command, one cycle later
            batch_stream_accept <= batch_stream_command & digital_on;
            batch_stream_reject <= batch_stream_command & ~digital_on;
        end
    end

    // measurement cycle: short modes stretch by half when digital is on
    wire short_mode = (meas_mode == `MODE_HIGH) || (meas_mode == `MODE_CUSTOM);
    wire [16:0] base_ext = {1'b0, base_cycle_r};
    wire [16:0] stretched = base_ext + {2'h0, base_cycle_r[15:1]};
    // half is rounded down, so odd cycles stretch a little less
    // the extra bit keeps the stretched value from wrapping
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            eff_cycle <= 17'h00000;
        end else if (digital_on && short_mode) begin
            // high mode never gets here: its digital bit is cleared
            eff_cycle <= stretched;
        end else begin
            eff_cycle <= base_ext;
        end
    end

    // first held value tracking for hold-type measurement
    reg held_seen_r; // a valid result exists since the last reset
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            held_seen_r <= 1'b0;
        end else if (reset_active || !hold_type) begin
            held_seen_r <= 1'b0;
        end else if (meas_valid && meas_active) begin
            // only a result taken while measuring counts
            held_seen_r <= 1'b1;
        end
    end

    // clamp level lookup for current and voltage outputs
    reg [15:0] clamp_level;
    always @* begin
        // codes five to seven fall to the maximum level
        case (clamp_sel)
            `CLAMP_LOW: clamp_level = volt_out ? `VOLT_NEG10 : `CUR_4MA;
            `CLAMP_MID: clamp_level = volt_out ? `VOLT_ZERO : `CUR_12MA;
            `CLAMP_HIGH: clamp_level = volt_out ? `VOLT_POS10 : `CUR_20MA;
            `CLAMP_MIN: clamp_level = volt_out ? `VOLT_MIN : `CUR_MIN;
            default: clamp_level = volt_out ? `VOLT_MAX : `CUR_MAX;
        endcase
    end

    // non-measurement: core idle or reset input held
    // the reset input clamps or holds even in mid-measurement
    wire no_result_behaviour = ~meas_active | reset_active;
    // hold-type with nothing held yet falls back to the clamp
    wire use_clamp = ~hold_mode | (hold_type & ~held_seen_r);
    // a cycle of latency buys glitch-free outputs

    // judgment and linear outputs share one register stage
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            judge_out <= 3'h0;
            // reset shows the default clamp level at once
            linear_out <= `CUR_MAX;
        end else if (no_result_behaviour) begin
            if (use_clamp) begin
                // clamp: every judgment off
                judge_out <= 3'h0;
                linear_out <= clamp_level;
            end
            // hold mode keeps both outputs as they were
        end else if (meas_valid) begin
            // measuring: results load only when flagged valid
            judge_out <= meas_judge;
            linear_out <= meas_linear;
        end
    end

endmodule
`default_nettype wire

// ### rtl/sensor_io_map.vh
`ifndef SENSOR_IO_MAP_VH
`define SENSOR_IO_MAP_VH

// register word offsets
`define ADDR_CTRL 4'h0
`define ADDR_POLARITY 4'h1
`define ADDR_BASE_CYCLE 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_EFF_CYCLE 4'h4

// control field positions
`define CTRL_HOLD_BIT 0
`define CTRL_VOLT_BIT 1
`define CTRL_CLAMP_LO 2
`define CTRL_BANK_BIT 5
`define CTRL_DIGITAL_BIT 6
`define CTRL_MODE_LO 8
`define CTRL_HOLDTYPE_BIT 10

// reset values
`define CTRL_RESET 32'h0000000c
`define POLARITY_RESET 4'hf
`define BASE_CYCLE_RESET 16'h0064

// measurement modes
`define MODE_STANDARD 2'h0
`define MODE_HIGH 2'h1
`define MODE_CUSTOM 2'h2

// clamp selections
`define CLAMP_LOW 3'h0
`define CLAMP_MID 3'h1
`define CLAMP_HIGH 3'h2
`define CLAMP_MAX 3'h3
`define CLAMP_MIN 3'h4

// clamp levels, microamps and millivolts, signed
`define CUR_4MA 16'h0fa0
`define CUR_12MA 16'h2ee0
`define CUR_20MA 16'h4e20
`define CUR_MAX 16'h61a8
`define CUR_MIN 16'h07d0
`define VOLT_NEG10 16'hd8f0
`define VOLT_ZERO 16'h0000
`define VOLT_POS10 16'h2710
`define VOLT_MAX 16'h2af8
`define VOLT_MIN 16'hd508

// timing: clock rate and times in milliseconds
`define CLK_HZ 25000000
`define BANK_DELAY_MS 500
`define BANK_MAX_MS 30000
`define ZERO_MIN_MS 200
`define ZERO_MAX_MS 800
`define ZERO_CANCEL_MS 1000
`define MS_CYCLES(ms) (((ms) * (`CLK_HZ / 1000)))

`endif

// ### dv/sensor_io_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_io_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic meas_active,
    input wire logic meas_valid,
    input wire logic [2:0] meas_judge,
    input wire logic [15:0] meas_linear,
    input wire logic batch_stream_command,
    input wire logic [2:0] judge_out,
    input wire logic [15:0] linear_out,
    input wire logic trigger_pulse,
    input wire logic reset_active,
    input wire logic zero_reset_apply,
    input wire logic zero_reset_cancel,
    input wire logic zero_active,
    input wire logic [1:0] bank_sel,
    input wire logic bank_change_start,
    input wire logic busy,
    input wire logic batch_stream_accept,
    input wire logic batch_stream_reject
);
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // every batch command gets exactly one answer
    property p_batch;
        batch_stream_command |=> batch_stream_accept ^ batch_stream_reject;
    endproperty
    property p_busy_on;
        bank_change_start |=> busy;
    endproperty
    // bound covers the timeout plus pipeline slack
    property p_busy_end;
        $rose(busy) |-> ##[1:410] !busy;
    endproperty
    property p_trig;
        trigger_pulse |=> !trigger_pulse;
    endproperty
    property p_zero_on;
        zero_reset_apply |-> ##[0:2] zero_active;
    endproperty
    property p_zero_off;
        zero_reset_cancel |-> ##[0:2] !zero_active;
    endproperty
    property p_bank_new;
        bank_change_start |-> bank_sel != $past(bank_sel);
    endproperty
    property p_bank_hold;
        !bank_change_start |-> $stable(bank_sel);
    endproperty
    // reset off in the first cycle keeps the clamp from winning; the second-cycle term only narrows the check
    property p_follow;
        meas_active && meas_valid && !reset_active ##1 !reset_active
            |-> judge_out == $past(meas_judge) && linear_out == $past(meas_linear);
    endproperty
    a_batch: assert property (p_batch) else $error("batch answer wrong");
    a_busy_on: assert property (p_busy_on) else $error("busy missing");
    a_busy_end: assert property (p_busy_end) else $error("busy stuck");
    a_trig: assert property (p_trig) else $error("trigger too long");
    a_zero_on: assert property (p_zero_on) else $error("zero not set");
    a_zero_off: assert property (p_zero_off) else $error("zero not cleared");
    a_bank_new: assert property (p_bank_new) else $error("start without change");
    a_bank_hold: assert property (p_bank_hold) else $error("bank moved alone");
    a_follow: assert property (p_follow) else $error("outputs not loaded");
    c_bank: cover property (bank_change_start);
    c_apply: cover property (zero_reset_apply);
    c_accept: cover property (batch_stream_accept);
endmodule
bind sensor_external_io_control sensor_io_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .meas_active(meas_active), .meas_valid(meas_valid), .meas_judge(meas_judge),
    .meas_linear(meas_linear), .batch_stream_command(batch_stream_command),
    .judge_out(judge_out), .linear_out(linear_out), .trigger_pulse(trigger_pulse),
    .reset_active(reset_active), .zero_reset_apply(zero_reset_apply),
    .zero_reset_cancel(zero_reset_cancel), .zero_active(zero_active), .bank_sel(bank_sel),
    .bank_change_start(bank_change_start), .busy(busy),
    .batch_stream_accept(batch_stream_accept), .batch_stream_reject(batch_stream_reject));
`default_nettype wire

// ### dv/ext_controller.sv
`timescale 1ns/1ps
`default_nettype none
// external controller driving the four input wires
module ext_controller (
    input wire logic sys_clk,
    output logic [3:0] pins
);
    initial pins = 4'h0;
    // new levels land just after an edge
    task automatic drive(input logic [3:0] v);
        @(posedge sys_clk);
        pins <= v;
    endtask
    // zero reset press; a short one is a deliberate misuse
    task automatic press(input int n);
        @(posedge sys_clk);
        pins[3] <= 1'b1;
        repeat (n) @(posedge sys_clk);
        pins[3] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### dv/sensor_external_io_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_io_map.vh"
module sensor_external_io_control_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic meas_active;
    logic meas_valid;
    logic [2:0] meas_judge;
    logic [15:0] meas_linear;
    logic bank_done;
    logic batch_stream_command;
    wire [31:0] avs_readdata;
    wire [3:0] pins;
    wire [2:0] judge_out;
    wire [15:0] linear_out;
    wire [1:0] bank_sel;
    wire [16:0] eff_cycle;
    wire avs_waitrequest, trigger_pulse, reset_active, laser_disable_input, zero_reset_apply;
    wire zero_reset_cancel, zero_active, bank_change_start, busy, acc, rej;
    wire [1:0] evt = {busy, bank_change_start};
    int err_count = 0;
    int n_compared = 0;
    int n_trig = 0;
    int n_apply = 0;
    int n_cancel = 0;
    always #20 sys_clk = ~sys_clk;
    // short counts keep the run small
    sensor_external_io_control #(.BANK_DELAY_CYC(32'd50), .BANK_MAX_CYC(32'd400),
        .ZERO_MIN_CYC(32'd20), .ZERO_MAX_CYC(32'd80), .ZERO_CANCEL_CYC(32'd100)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .input_wire_zero(pins[0]),
        .input_wire_one(pins[1]), .input_wire_two(pins[2]), .input_wire_three(pins[3]),
        .meas_active(meas_active), .meas_valid(meas_valid), .meas_judge(meas_judge),
        .meas_linear(meas_linear), .bank_done(bank_done),
        .batch_stream_command(batch_stream_command), .judge_out(judge_out),
        .linear_out(linear_out), .trigger_pulse(trigger_pulse), .reset_active(reset_active),
        .laser_disable_input(laser_disable_input), .zero_reset_apply(zero_reset_apply),
        .zero_reset_cancel(zero_reset_cancel), .zero_active(zero_active), .bank_sel(bank_sel),
        .bank_change_start(bank_change_start), .busy(busy), .batch_stream_accept(acc),
        .batch_stream_reject(rej), .eff_cycle(eff_cycle));
    ext_controller u_plc (.sys_clk(sys_clk), .pins(pins));
    // pulse tallies, so short pulses are never missed
    always @(posedge sys_clk) begin
        n_trig += (trigger_pulse === 1'b1);
        n_apply += (zero_reset_apply === 1'b1);
        n_cancel += (zero_reset_cancel === 1'b1);
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            err_count++;
            summarize();
        end
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    // bounded wait on a design event bit
    task automatic wait_evt(input int b, input logic lvl, output int n);
        for (n = 1; n <= 1000; n++) begin
            @(posedge sys_clk);
            if (evt[b] === lvl) return;
        end
        err_count++;
        summarize();
    endtask
    initial begin
        int n;
        int k;
        logic [1:0] c;
        logic [15:0] tab [0:9];
        tab = '{`CUR_4MA, `CUR_12MA, `CUR_20MA, `CUR_MAX, `CUR_MIN,
                `VOLT_NEG10, `VOLT_ZERO, `VOLT_POS10, `VOLT_MAX, `VOLT_MIN};
        avs_address <= 4'h0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h0;
        meas_active <= 1'b0;
        meas_valid <= 1'b0;
        meas_judge <= 3'h0;
        meas_linear <= 16'h0;
        bank_done <= 1'b0;
        batch_stream_command <= 1'b0;
        cyc(5);
        rst_n <= 1'b1;
        cyc(1);
        chk(linear_out, `CUR_MAX);
        rd(`ADDR_CTRL, `CTRL_RESET);
        rd(`ADDR_POLARITY, `POLARITY_RESET);
        rd(`ADDR_BASE_CYCLE, `BASE_CYCLE_RESET);
        rd(4'h9, 32'h0);
        // every clamp level, current then voltage
        for (k = 0; k < 10; k++) begin
            wr(`ADDR_CTRL, ((k % 5) << 2) | ((k / 5) << 1));
            cyc(2);
            chk(linear_out, tab[k]);
            chk(judge_out, 3'h0);
        end
        // spare clamp codes fall back to the maximum level
        wr(`ADDR_CTRL, 32'h00000014);
        cyc(2);
        chk(linear_out, `CUR_MAX);
        // hold mode with hold-type: clamp until a value is held
        wr(`ADDR_CTRL, 32'h0000040d);
        cyc(2);
        chk(linear_out, `CUR_MAX);
        meas_active <= 1'b1;
        meas_valid <= 1'b1;
        meas_judge <= 3'h5;
        meas_linear <= 16'h1234;
        cyc(1);
        meas_valid <= 1'b0;
        cyc(1);
        meas_active <= 1'b0;
        cyc(3);
        chk(judge_out, 3'h5);
        chk(linear_out, 16'h1234);
        // digital output with each mode
        for (k = 0; k < 3; k++) begin
            wr(`ADDR_CTRL, 32'h0000004c | (k << 8));
            cyc(2);
            rd(`ADDR_EFF_CYCLE, (k == 2) ? 32'h96 : 32'h64);
            chk(eff_cycle, (k == 2) ? 32'h96 : 32'h64);
            rd(`ADDR_CTRL, (k == 1) ? 32'h10c : 32'h4c | (k << 8));
            batch_stream_command <= 1'b1;
            cyc(1);
            batch_stream_command <= 1'b0;
            cyc(1);
            chk({acc, rej}, (k == 1) ? 2'b01 : 2'b10);
        end
        // wire one active low while the pin is low: reset clamps
        wr(`ADDR_CTRL, `CTRL_RESET);
        meas_active <= 1'b1;
        meas_valid <= 1'b1;
        cyc(2);
        chk(linear_out, 16'h1234);
        wr(`ADDR_POLARITY, 32'hd);
        meas_valid <= 1'b0;
        cyc(4);
        chk(linear_out, `CUR_MAX);
        chk(judge_out, 3'h0);
        rd(`ADDR_STATUS, 32'h10);
        wr(`ADDR_POLARITY, 32'hf);
        u_plc.drive(4'h5);
        cyc(5);
        chk({reset_active, laser_disable_input, 16'(n_trig)}, {2'b01, 16'd1});
        u_plc.drive(4'h0);
        u_plc.press(40);
        cyc(5);
        chk({16'(n_apply), zero_active}, {16'd1, 1'b1});
        u_plc.press(120);
        cyc(5);
        chk({16'(n_cancel), zero_active}, {16'd1, 1'b0});
        u_plc.press(10);
        cyc(5);
        chk(n_apply, 1);
        // bank assignment: walk all four banks, last one times out
        wr(`ADDR_CTRL, 32'h0000002c);
        for (k = 1; k <= 4; k++) begin
            c = k[1:0];
            u_plc.drive({2'b00, c[0], c[1]});
            wait_evt(0, 1'b1, n);
            chk(n >= 50 && n <= 60, 1);
            chk({bank_sel, reset_active}, {c, 1'b0});
            cyc(1);
            chk(busy, 1);
            bank_done <= (k < 4);
            cyc(1);
            bank_done <= 1'b0;
            wait_evt(1, 1'b0, n);
            chk((k < 4) ? n <= 3 : n >= 380 && n <= 410, 1);
        end
        chk(n_trig, 1);
        summarize();
    end
endmodule
`default_nettype wire
